// ### qdc_chan_bank.v
`include "qdc_consts.vh"

module qdc_chan_bank (
    input wire clock,
    input wire rst_n,
    input wire clear,
    input wire [`QDC_CHANS-1:0] load_in,
    input wire load_all,
    input wire xfer_all,
    input wire [`QDC_DATA_BITS-1:0] data,
    output wire [`QDC_CHANS*`QDC_DATA_BITS-1:0] codes
);

    genvar i;
    generate
        for (i = 0; i < `QDC_CHANS; i = i + 1) begin : g_chan
            reg [`QDC_DATA_BITS-1:0] in_q;
            reg [`QDC_DATA_BITS-1:0] dac_q;
            wire [`QDC_DATA_BITS-1:0] in_d;
            assign in_d = (load_in[i] || load_all) ? data : in_q;
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    in_q <= `QDC_CODE_RST;
                    dac_q <= `QDC_CODE_RST;
                end else if (clear) begin
                    in_q <= `QDC_CODE_RST;
                    dac_q <= `QDC_CODE_RST;
                end else begin
                    in_q <= in_d;
                    // Transfer sees the input register as just loaded
                    if (xfer_all || load_all) begin
                        dac_q <= in_d;
                    end
                end
            end
            assign codes[i*`QDC_DATA_BITS +: `QDC_DATA_BITS] = dac_q;
        end
    endgenerate

endmodule // qdc_chan_bank

// ### qdc_consts.vh
`ifndef QDC_CONSTS_VH
`define QDC_CONSTS_VH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define QDC_WORD_BITS 16
`define QDC_DATA_BITS 12
`define QDC_CHANS 4
`define QDC_CNT_W 5
`define QDC_CNT_FULL 5'h10
`define QDC_CNT_SAT 5'h11
`define QDC_CMD_HI 15
`define QDC_CMD_LO 12
`define QDC_DATA_HI 11

// ----------------------------------------
// Command codes {addr_hi, addr_lo, ctrl_hi, ctrl_lo}
// ----------------------------------------
`define QDC_CMD_NOP 4'h0
`define QDC_CMD_UPD_ALL 4'h4
`define QDC_CMD_LOAD_ALL 4'h8
`define QDC_CMD_SHDN 4'hc
`define QDC_CMD_UPO_LO 4'h2
`define QDC_CMD_UPO_HI 4'h6
`define QDC_CMD_MODE0 4'ha
`define QDC_CMD_MODE1 4'he

// ----------------------------------------
// Reset values
// ----------------------------------------
`define QDC_CODE_RST 12'h000
`define QDC_SR_RST 16'h0000
`define QDC_CNT_RST 5'h00
`define QDC_SYNC_RST 2'h0
`define QDC_SYNC_SET 2'h3

`endif

// ### qdc_host_model.sv
module qdc_host_model (
    input wire logic clock,
    input wire logic dout,
    output logic sclk,
    output logic cs_n,
    output logic din,
    output logic [15:0] cap_rise,
    output logic [15:0] cap_fall
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // Top n bits of w, MSB first; echo sampled after each clock edge
    task automatic xfer(input logic [15:0] w, input int n);
        @(posedge clock);
        #1 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = w[15-i];
            #80 sclk = 1'b1;
            #60 cap_rise = {cap_rise[14:0], dout};
            #20 sclk = 1'b0;
            #60 cap_fall = {cap_fall[14:0], dout};
            #20;
        end
        cs_n = 1'b1;
        din = ~din;
        #200;
    endtask
endmodule // qdc_host_model

// ### qdc_serial_ctrl.v
`include "qdc_consts.vh"


module qdc_serial_ctrl (
    input wire clock,
    input wire rst_n,
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire clear_all_n,
    input wire shutdown_lockout_n,
    output reg dout,
    output reg user_logic_out,
    output reg power_down,
    output reg echo_rise_mode,
    output wire [`QDC_DATA_BITS-1:0] code_value_0,
    output wire [`QDC_DATA_BITS-1:0] code_value_1,
    output wire [`QDC_DATA_BITS-1:0] code_value_2,
    output wire [`QDC_DATA_BITS-1:0] code_value_3
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    reg [1:0] sclk_sync_q;
    reg [1:0] cs_sync_q;
    reg [1:0] din_sync_q;
    reg [1:0] clr_sync_q;
    reg [1:0] lock_sync_q;
    reg sclk_prev_q;
    reg cs_prev_q;

    // Idle levels at reset so no false edge follows release
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_sync_q <= `QDC_SYNC_RST;
            cs_sync_q <= `QDC_SYNC_SET;
            din_sync_q <= `QDC_SYNC_RST;
            clr_sync_q <= `QDC_SYNC_SET;
            lock_sync_q <= `QDC_SYNC_SET;
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], sclk};
            cs_sync_q <= {cs_sync_q[0], cs_n};
            din_sync_q <= {din_sync_q[0], din};
            clr_sync_q <= {clr_sync_q[0], clear_all_n};
            lock_sync_q <= {lock_sync_q[0], shutdown_lockout_n};
            sclk_prev_q <= sclk_sync_q[1];
            cs_prev_q <= cs_sync_q[1];
        end
    end

    wire sclk_s = sclk_sync_q[1];
    wire cs_low = !cs_sync_q[1];
    wire clear = !clr_sync_q[1];
    wire lockout = !lock_sync_q[1];
    // Edges of the synchronised pins, one system clock wide
    wire sclk_rise = sclk_s && !sclk_prev_q;
    wire sclk_fall = !sclk_s && sclk_prev_q;
    wire cs_rise = cs_sync_q[1] && !cs_prev_q;

    // ----------------------------------------
    // Shift register and bit counter
    // ----------------------------------------
    reg [`QDC_WORD_BITS-1:0] shift_q;
    reg [`QDC_CNT_W-1:0] count_q;
    reg out_bit_q;

    // Count saturates so a long frame never wraps back to sixteen
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= `QDC_SR_RST;
            count_q <= `QDC_CNT_RST;
            out_bit_q <= 1'b0;
        end else if (clear) begin
            shift_q <= `QDC_SR_RST;
            count_q <= `QDC_CNT_RST;
            out_bit_q <= 1'b0;
        end else begin
            if (cs_low && sclk_rise) begin
                out_bit_q <= shift_q[`QDC_WORD_BITS-1];
                shift_q <= {shift_q[`QDC_WORD_BITS-2:0], din_sync_q[1]};
                if (count_q != `QDC_CNT_SAT) begin
                    count_q <= count_q + 5'h01;
                end
            end
            if (cs_rise) begin
                count_q <= `QDC_CNT_RST;
            end
        end
    end

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    // Short or long frames are dropped at select rise
    wire word_ok = cs_rise && (count_q == `QDC_CNT_FULL);
    wire [3:0] cmd = shift_q[`QDC_CMD_HI:`QDC_CMD_LO];
    wire [`QDC_DATA_BITS-1:0] word_data = shift_q[`QDC_DATA_HI:0];
    wire is_load = cmd[0]; // ctrl_bit_lo set: load input register
    wire [1:0] chan_sel = cmd[3:2]; // chan_addr_hi, chan_addr_lo

    reg [`QDC_CHANS-1:0] load_in;
    reg load_all;
    reg xfer_all;
    reg wake;

    always @* begin
        load_in = {`QDC_CHANS{1'b0}};
        load_all = 1'b0;
        xfer_all = 1'b0;
        wake = 1'b0;
        if (word_ok && !clear) begin
            // Load with ctrl_bit_hi set also updates every converter
            if (is_load) begin
                load_in[chan_sel] = 1'b1;
                xfer_all = cmd[1];
                wake = cmd[1];
            end else begin
                case (cmd)
                    `QDC_CMD_UPD_ALL, `QDC_CMD_MODE0, `QDC_CMD_MODE1: begin
                        xfer_all = 1'b1;
                        wake = 1'b1;
                    end
                    `QDC_CMD_LOAD_ALL: begin
                        load_all = 1'b1;
                        wake = 1'b1;
                    end
                    default: begin
                        wake = 1'b0;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Mode, user output, power-down, echo
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            user_logic_out <= 1'b0;
            power_down <= 1'b0;
            echo_rise_mode <= 1'b0;
            dout <= 1'b0;
        end else if (clear) begin
            user_logic_out <= 1'b0;
            power_down <= 1'b0;
            echo_rise_mode <= 1'b0;
            dout <= 1'b0;
        end else begin
            if (word_ok && !is_load) begin
                case (cmd)
                    `QDC_CMD_UPO_LO: user_logic_out <= 1'b0;
                    `QDC_CMD_UPO_HI: user_logic_out <= 1'b1;
                    `QDC_CMD_MODE0: echo_rise_mode <= 1'b0;
                    `QDC_CMD_MODE1: echo_rise_mode <= 1'b1;
                    default: echo_rise_mode <= echo_rise_mode;
                endcase
            end
            // Lockout low also wakes a part already shut down
            if (lockout) begin
                power_down <= 1'b0;
            end else if (word_ok && cmd == `QDC_CMD_SHDN) begin
                power_down <= 1'b1;
            end else if (wake) begin
                power_down <= 1'b0;
            end
            // Old MSB leaves: 16 clocks on rise, 16.5 on fall
            if (echo_rise_mode && sclk_rise && cs_low) begin
                dout <= shift_q[`QDC_WORD_BITS-1];
            end else if (!echo_rise_mode && sclk_fall && cs_low) begin
                dout <= out_bit_q;
            end
        end
    end

    // ----------------------------------------
    // Channel registers
    // ----------------------------------------
    wire [`QDC_CHANS*`QDC_DATA_BITS-1:0] codes;

    // Power-down leaves the codes in place; only the analog side idles
    qdc_chan_bank qdc_chan_bank_inst (
        .clock(clock),
        .rst_n(rst_n),
        .clear(clear),
        .load_in(load_in),
        .load_all(load_all),
        .xfer_all(xfer_all),
        .data(word_data),
        .codes(codes)
    );

    assign code_value_0 = codes[0*`QDC_DATA_BITS +: `QDC_DATA_BITS];
    assign code_value_1 = codes[1*`QDC_DATA_BITS +: `QDC_DATA_BITS];
    assign code_value_2 = codes[2*`QDC_DATA_BITS +: `QDC_DATA_BITS];
    assign code_value_3 = codes[3*`QDC_DATA_BITS +: `QDC_DATA_BITS];

endmodule // qdc_serial_ctrl

// ### qdc_serial_ctrl_monitor.sv
module qdc_serial_ctrl_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic clear_all_n,
    input wire logic shutdown_lockout_n,
    input wire logic dout,
    input wire logic user_logic_out,
    input wire logic power_down,
    input wire logic echo_rise_mode,
    input wire logic [11:0] code_value_0,
    input wire logic [11:0] code_value_1,
    input wire logic [11:0] code_value_2,
    input wire logic [11:0] code_value_3
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire [47:0] codes = {code_value_3, code_value_2, code_value_1, code_value_0};
    sequence s_sel;
        (!cs_n && clear_all_n && shutdown_lockout_n)[*6];
    endsequence
    sequence s_idle;
        (cs_n && clear_all_n && shutdown_lockout_n)[*8];
    endsequence
    a_clear_zeroes: assert property ((!clear_all_n)[*5] |->
        codes == 48'h0000_0000_0000 && !dout && !user_logic_out) else $error("clear missed");
    a_codes_hold: assert property (s_sel |-> $stable(codes)) else $error("codes moved");
    a_upo_mode_hold: assert property (s_sel |-> $stable({user_logic_out, echo_rise_mode}))
        else $error("pin moved in frame");
    a_pd_hold: assert property (s_sel |-> $stable(power_down)) else $error("pd moved");
    a_lockout_wakes: assert property ((!shutdown_lockout_n)[*5] |-> !power_down)
        else $error("lockout ignored");
    a_idle_quiet: assert property (s_idle |-> $stable({codes, power_down, user_logic_out}))
        else $error("idle change");
    a_echo_idle: assert property (s_idle |-> $stable(dout)) else $error("echo idle");
    a_echo_sclk: assert property (($stable(sclk) && clear_all_n)[*6] |-> $stable(dout))
        else $error("echo without clock");
endmodule // qdc_serial_ctrl_monitor
bind qdc_serial_ctrl qdc_serial_ctrl_monitor qdc_serial_ctrl_monitor_inst (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .clear_all_n(clear_all_n), .shutdown_lockout_n(shutdown_lockout_n), .dout(dout),
    .user_logic_out(user_logic_out), .power_down(power_down), .echo_rise_mode(echo_rise_mode),
    .code_value_0(code_value_0), .code_value_1(code_value_1), .code_value_2(code_value_2),
    .code_value_3(code_value_3));

// ### qdc_tb.sv
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clear_all_n = 1'b1;
    logic shutdown_lockout_n = 1'b1;
    logic sclk, cs_n, din, dout, user_logic_out, power_down, echo_rise_mode;
    logic [11:0] cv0, cv1, cv2, cv3;
    logic [15:0] cap_rise, cap_fall;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    qdc_serial_ctrl qdc_serial_ctrl_inst (.clock(clock), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .din(din), .clear_all_n(clear_all_n),
        .shutdown_lockout_n(shutdown_lockout_n), .dout(dout), .user_logic_out(user_logic_out),
        .power_down(power_down), .echo_rise_mode(echo_rise_mode), .code_value_0(cv0),
        .code_value_1(cv1), .code_value_2(cv2), .code_value_3(cv3));
    qdc_host_model qdc_host_model_inst (.clock(clock), .dout(dout), .sclk(sclk), .cs_n(cs_n),
        .din(din), .cap_rise(cap_rise), .cap_fall(cap_fall));
    task automatic send(input logic [15:0] w, input int n = 16);
        qdc_host_model_inst.xfer(w, n);
    endtask
    task automatic codes(input logic [47:0] e);
        `CHK({cv3, cv2, cv1, cv0}, e)
    endtask
    task automatic finish_test();
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            finish_test();
        end
    end
    initial begin
        #16 rst_n = 1'b1;
        repeat (5) @(posedge clock);
        #1 codes(48'h0000_0000_0000);
        send(16'h5ABC);
        codes(48'h0000_0000_0000);
        send(16'h4000);
        codes(48'h0000_00AB_C000);
        send(16'h3123);
        codes(48'h0000_00AB_C123);
        send(16'h8FFF);
        codes(48'hFFFF_FFFF_FFFF);
        send(16'h6000);
        `CHK(user_logic_out, 1'b1)
        send(16'h2000, 15);
        `CHK(user_logic_out, 1'b1)
        send(16'h2000);
        `CHK(user_logic_out, 1'b0)
        shutdown_lockout_n = 1'b0;
        send(16'hC000);
        `CHK(power_down, 1'b0)
        shutdown_lockout_n = 1'b1;
        send(16'hC000);
        `CHK(power_down, 1'b1)
        send(16'h9555);
        `CHK(power_down, 1'b1)
        codes(48'hFFFF_FFFF_FFFF);
        send(16'h4000);
        `CHK(power_down, 1'b0)
        codes(48'hFFF5_55FF_FFFF);
        send(16'hC000);
        `CHK(power_down, 1'b1)
        shutdown_lockout_n = 1'b0;
        repeat (6) @(posedge clock);
        #1 `CHK(power_down, 1'b0)
        codes(48'hFFF5_55FF_FFFF);
        shutdown_lockout_n = 1'b1;
        #15000;
        send(16'hE5A5);
        `CHK(echo_rise_mode, 1'b1)
        send(16'h0000);
        `CHK(cap_rise, 16'hE5A5)
        send(16'hA3C3);
        `CHK(echo_rise_mode, 1'b0)
        send(16'h0000);
        `CHK(cap_fall, 16'hA3C3)
        codes(48'hFFF5_55FF_FFFF);
        send(16'h6000);
        clear_all_n = 1'b0;
        repeat (6) @(posedge clock);
        #1 codes(48'h0000_0000_0000);
        `CHK({user_logic_out, dout}, 2'b00)
        clear_all_n = 1'b1;
        finish_test();
    end
endmodule // tb
